// [hdl/edge_one_shot_timer.sv]
// edge-triggered one-shot timer with pwm drive and apb register slave
`timescale 1ns/1ns
module edge_one_shot_timer
  import one_shot_pkg::*;
(
  input wire logic sys_clk, // 100 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic timerClockInput, // timer clock, counted on its rising edge
  input wire logic externalStartSignal, // external start signal
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write when high
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data, registered
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic pwmDrive, // pwm drive to compare unit
  output logic [TIMER_W-1:0] countValue // current count
);
  typedef struct packed {
    timer_state_type state;
    logic enable;
    logic [MODE_W-1:0] mode;
    logic [TIMER_W-1:0] period;
    logic [TIMER_W-1:0] pulseWidth;
    logic [TIMER_W-1:0] count;
    logic pwmDrive;
    logic [31:0] prdata;
  } timer_regs_type;

  timer_regs_type q;
  timer_regs_type next_q;
  logic tick;
  logic startRise;
  logic startFall;
  logic trigger;
  logic mapped;
  logic access;
  logic [31:0] readWord;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on timer clock and start signal

  signal_edge clockEdge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level(timerClockInput),
    .rise(tick),
    .fall()
  );

  signal_edge startEdge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .level(externalStartSignal),
    .rise(startRise),
    .fall(startFall)
  );

  // qualifying edge per mode; other modes never trigger
  always_comb begin
    case (q.mode)
      MODE_RISE: trigger = startRise;
      MODE_FALL: trigger = startFall;
      MODE_ANY: trigger = startRise | startFall;
      default: trigger = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, error on unmapped address

  assign mapped = (paddr == CTRL_ADDR) || (paddr == PERIOD_ADDR) ||
                  (paddr == PULSE_ADDR) || (paddr == STATUS_ADDR);
  assign access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // read mux, sampled in the setup cycle so prdata is a flop in access
  always_comb begin
    readWord = WORD_ZERO;
    case (paddr)
      CTRL_ADDR: begin
        readWord[ENABLE_BIT] = q.enable;
        readWord[MODE_MSB:MODE_LSB] = q.mode;
      end
      PERIOD_ADDR: readWord[TIMER_W-1:0] = q.period;
      PULSE_ADDR: readWord[TIMER_W-1:0] = q.pulseWidth;
      STATUS_ADDR: begin
        readWord[TIMER_W-1:0] = q.count;
        readWord[PWM_BIT] = q.pwmDrive;
        readWord[RUN_BIT] = (q.state == COUNTING);
      end
      default: readWord = WORD_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: counting first, software writes last so a set wins

  always_comb begin
    next_q = q;
    if (psel && !penable && !pwrite) begin
      next_q.prdata = readWord;
    end
    case (q.state)
      ARMED: begin
        // enable alone does nothing; an edge must arrive while it is set
        if (q.enable && trigger) begin
          next_q.state = COUNTING;
          next_q.pwmDrive = 1'b1;
        end
      end
      COUNTING: begin
        if (!q.enable) begin
          // halted: count and pwm held, re-arm for a fresh edge
          next_q.state = ARMED;
        end else begin
          if (q.count == q.pulseWidth) begin
            next_q.pwmDrive = 1'b0;
          end
          if (tick) begin
            if (q.count == q.period) begin
              next_q.count = COUNT_RESET;
              next_q.enable = 1'b0;
              next_q.pwmDrive = 1'b0;
              next_q.state = ARMED;
            end else begin
              next_q.count = q.count + COUNT_STEP;
            end
          end
        end
      end
      default: next_q.state = ARMED;
    endcase
    // register writes take effect at the access edge
    if (access && pwrite) begin
      case (paddr)
        CTRL_ADDR: begin
          next_q.enable = pwdata[ENABLE_BIT];
          next_q.mode = pwdata[MODE_MSB:MODE_LSB];
        end
        PERIOD_ADDR: next_q.period = pwdata[TIMER_W-1:0];
        PULSE_ADDR: next_q.pulseWidth = pwdata[TIMER_W-1:0];
        default: next_q.period = q.period;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.state <= ARMED;
      q.enable <= 1'b0;
      q.mode <= MODE_RESET;
      q.period <= PERIOD_RESET;
      q.pulseWidth <= PULSE_RESET;
      q.count <= COUNT_RESET;
      q.pwmDrive <= 1'b0;
      q.prdata <= WORD_ZERO;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pwmDrive = q.pwmDrive;
  assign countValue = q.count;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  logic ctrlWrite;
  assign ctrlWrite = access && pwrite && (paddr == CTRL_ADDR);

  a_edge_starts_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.state == ARMED && q.enable && trigger |=> q.state == COUNTING && q.pwmDrive)
    else $error("qualifying edge did not start the timer");

  a_no_edge_no_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.state == ARMED && !(q.enable && trigger) |=> q.state == ARMED)
    else $error("timer started without a qualifying edge");

  a_period_clears_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.state == COUNTING && q.enable && tick && q.count == q.period && !ctrlWrite
    |=> !q.enable && q.count == COUNT_RESET && q.state == ARMED)
    else $error("period match did not clear enable and count");

  a_halt_needs_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !q.enable |=> q.state == ARMED)
    else $error("timer kept running after enable cleared");

  a_pwm_off_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.state == COUNTING && q.enable && q.count == q.pulseWidth |=> !q.pwmDrive)
    else $error("pwm drive still on after pulse width match");

  a_pwm_stays_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.state == ARMED && !q.pwmDrive && !(q.enable && trigger) |=> !q.pwmDrive)
    else $error("pwm drive rose without a trigger edge");

  a_count_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    q.state == COUNTING && q.enable && tick && q.count != q.period
    |=> q.count == $past(q.count) + COUNT_STEP)
    else $error("count did not advance by one on timer clock");

  a_count_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !q.enable ##1 !q.enable |-> q.count == $past(q.count, 1) && q.state == ARMED)
    else $error("count changed while enable clear");
endmodule

// [hdl/one_shot_pkg.sv]
// constants and types shared by the edge-triggered one-shot timer
package one_shot_pkg;
  localparam int TIMER_W = 8;
  localparam int ADDR_W = 12;
  localparam int MODE_W = 5;
  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] PERIOD_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] PULSE_ADDR = 12'h008;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h00C;
  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 5;
  localparam int PWM_BIT = 8;
  localparam int RUN_BIT = 9;
  // mode codes handled here
  localparam logic [MODE_W-1:0] MODE_RISE = 5'h09;
  localparam logic [MODE_W-1:0] MODE_FALL = 5'h0A;
  localparam logic [MODE_W-1:0] MODE_ANY = 5'h0B;
  // reset values and count step
  localparam logic [TIMER_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [TIMER_W-1:0] PERIOD_RESET = 8'h00;
  localparam logic [TIMER_W-1:0] PULSE_RESET = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] COUNT_STEP = 8'h01;

  typedef enum logic [1:0] {
    ARMED = 2'b01,
    COUNTING = 2'b10
  } timer_state_type;
endpackage

// [hdl/signal_edge.sv]
// rising and falling edge detector for a synchronous input
`timescale 1ns/1ns
module signal_edge (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic level, // sampled input
  output logic rise, // one-cycle pulse on low-to-high
  output logic fall // one-cycle pulse on high-to-low
);
  logic previous;

  // remember last level; reset low so a high input at release reads as a rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      previous <= 1'b0;
    end else begin
      previous <= level;
    end
  end

  // edges compare present level with the stored one
  assign rise = level & ~previous;
  assign fall = ~level & previous;
endmodule

// [bench/far_side_model.sv]
// far side: timer clock source and external start signal source
`timescale 1ns/1ns
module far_side_model (
  input wire logic sys_clk, // system clock
  output logic timerClockInput = 1'b0, // timer clock to the block
  output logic externalStartSignal = 1'b0 // start signal to the block
);
  // one tick, held two cycles so the rise is seen, then the count lands
  task automatic tick();
    timerClockInput <= 1'b1;
    repeat (2) @(posedge sys_clk);
    timerClockInput <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // one edge on the start line, new level handed back
  task automatic flip(output logic lvl);
    lvl = ~externalStartSignal;
    externalStartSignal <= lvl;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule

// [bench/tb_edge_triggered_one_shot_timer.sv]
// self-checking bench for the edge-triggered one-shot timer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_edge_triggered_one_shot_timer
  import one_shot_pkg::*;
;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, lvl;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdVal;
  logic pready, pslverr, pwmDrive, errSeen, timerClockInput, externalStartSignal;
  logic [TIMER_W-1:0] countValue;
  logic [MODE_W-1:0] modes [3] = '{MODE_RISE, MODE_FALL, MODE_ANY};
  int n_mismatch = 0, compares = 0, per, wid;
  always #5 sys_clk = ~sys_clk;
  edge_one_shot_timer u_edge_one_shot_timer (.sys_clk(sys_clk), .rst_n(rst_n),
    .timerClockInput(timerClockInput), .externalStartSignal(externalStartSignal),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwmDrive(pwmDrive),
    .countValue(countValue));
  far_side_model u_far_side_model (.sys_clk(sys_clk), .timerClockInput(timerClockInput),
    .externalStartSignal(externalStartSignal));
  ////////////////////////////////////////////////////////////
  // one apb transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdVal = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(27166));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // every start mode, random period and pulse width
    foreach (modes[i]) begin
      per = 2 + $urandom % 4;
      wid = 1 + $urandom % (per - 1);
      // park the start line so the first armed edge is the wrong one for rise and fall
      if (modes[i] != MODE_ANY && externalStartSignal != (modes[i] == MODE_RISE))
        u_far_side_model.flip(lvl);
      apb(1, PERIOD_ADDR, 32'(per));
      apb(1, PULSE_ADDR, 32'(wid));
      apb(1, CTRL_ADDR, {26'h0, modes[i], 1'b1});
      u_far_side_model.tick();
      `CHK("count without edge", 0, countValue)
      u_far_side_model.flip(lvl);
      if (!(modes[i] == MODE_ANY || (modes[i] == MODE_RISE) == lvl)) begin
        u_far_side_model.tick();
        `CHK("count after wrong edge", 0, countValue)
        `CHK("pwm after wrong edge", 0, pwmDrive)
        u_far_side_model.flip(lvl);
      end
      `CHK("pwm on edge", 1, pwmDrive)
      for (int k = 1; k <= per; k++) begin
        u_far_side_model.tick();
        `CHK("count", k, countValue)
        `CHK("pwm", k < wid, pwmDrive)
      end
      u_far_side_model.tick();
      `CHK("count at end", 0, countValue)
      `CHK("pwm at end", 0, pwmDrive)
      apb(0, CTRL_ADDR, 32'h0);
      `CHK("enable cleared", 0, rdVal[ENABLE_BIT])
      $display("test mode %0h done", modes[i]);
    end
    // halt mid-run: count held, no resume without a fresh edge
    apb(1, PERIOD_ADDR, 32'h9);
    apb(1, PULSE_ADDR, 32'h3);
    apb(1, CTRL_ADDR, {26'h0, MODE_ANY, 1'b1});
    u_far_side_model.flip(lvl);
    u_far_side_model.tick();
    u_far_side_model.tick();
    apb(1, CTRL_ADDR, {26'h0, MODE_ANY, 1'b0});
    u_far_side_model.tick();
    `CHK("held count", 2, countValue)
    apb(1, CTRL_ADDR, {26'h0, MODE_ANY, 1'b1});
    u_far_side_model.tick();
    `CHK("no resume", 2, countValue)
    `CHK("pwm extended", 1, pwmDrive)
    u_far_side_model.flip(lvl);
    u_far_side_model.tick();
    `CHK("resumed count", 3, countValue)
    apb(0, STATUS_ADDR, 32'h0);
    `CHK("status count", 3, rdVal[7:0])
    apb(0, 12'hFF0, 32'h0);
    `CHK("unmapped error", 1, errSeen)
    $display("test halt and resume done");
    end_sim();
  end
endmodule
